// [ext_irq_pkg.sv]
// Purpose: Shared constants for the external interrupt extension block
// Assumes: Wishbone classic slave, 20 MHz core clock
// Notes: Register offsets are byte addresses on a 32-bit bus
package ext_irq_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] XCTL_OFFSET = 8'hc0;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hc4;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'hc8;
    localparam logic [7:0] CORE_OFFSET = 8'hcc;
    localparam logic [7:0] VECTOR_OFFSET = 8'hd0;
    localparam logic [7:0] LEGACY_OFFSET = 8'hd4;
    localparam logic [7:0] XCTL_RESET = 8'h00;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int A_TRIG_BIT = 0;
    localparam int A_PEND_BIT = 1;
    localparam int A_EN_BIT = 2;
    localparam int A_PRIO_BIT = 3;
    localparam int B_TRIG_BIT = 4;
    localparam int B_PEND_BIT = 5;
    localparam int B_EN_BIT = 6;
    localparam int B_PRIO_BIT = 7;
    // Core register fields: service ack, return, emulation
    localparam int CORE_ACK_BIT = 0;
    localparam int CORE_RETI_BIT = 1;
    localparam int CORE_EMU_BIT = 2;
    // Event status bits
    localparam int EV_TAKEN_BIT = 0;
    localparam int EV_A_BIT = 1;
    localparam int EV_B_BIT = 2;
    localparam int NUM_SRC = 8;
    // ****************************************
    // Vector table, indexed by polling order
    // ****************************************
    localparam logic [7:0] VEC_EXT0 = 8'h03;
    localparam logic [7:0] VEC_TMR0 = 8'h0b;
    localparam logic [7:0] VEC_EXT1 = 8'h13;
    localparam logic [7:0] VEC_TMR1 = 8'h1b;
    localparam logic [7:0] VEC_SER = 8'h23;
    localparam logic [7:0] VEC_TMR2 = 8'h2b;
    localparam logic [7:0] VEC_XA = 8'h33;
    localparam logic [7:0] VEC_XB = 8'h3b;
endpackage : ext_irq_pkg

// [ext_irq_input.sv]
// Purpose: One added external interrupt input: sync, trigger, pending flag
// Assumes: Pin is asynchronous to clk
// Notes: Everything holds still while frozen
`timescale 1ns/1ps
`default_nettype none
module ext_irq_input (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    input wire logic freeze,
    input wire logic edge_mode,
    input wire logic sw_wr,
    input wire logic sw_pend,
    input wire logic serviced,
    output logic request,
    output logic pend,
    output logic edge_seen
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pend;
    } state_t;
    state_t st, next_st;
    // Two flops before any logic reads the pin; edge compares s2 with prev
    always_comb begin
        next_st = st;
        edge_seen = 1'b0;
        if (!freeze) begin
            next_st.s1 = pin;
            next_st.s2 = st.s1;
            next_st.prev = st.s2;
            edge_seen = edge_mode && st.prev && !st.s2;
            if (sw_wr)
                next_st.pend = sw_pend;
            if (serviced && edge_mode)
                next_st.pend = 1'b0;
            // Set wins over a clear in the same cycle
            if (edge_seen)
                next_st.pend = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn)
            st <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, pend: 1'b0};
        else
            st <= next_st;
    end
    assign pend = st.pend;
    // Level mode requests while the pin is held low
    assign request = edge_mode ? st.pend : !st.s2;
endmodule : ext_irq_input
`default_nettype wire

// [ext_irq_arbiter.sv]
// Purpose: Pick the winning source by priority level, then polling order
// Assumes: Inputs are per-source request and priority vectors, enables already applied
// Notes: Index 0 polls first
`timescale 1ns/1ps
`default_nettype none
module ext_irq_arbiter #(
    parameter int N = 8
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] hi,
    output logic found,
    output logic win_hi,
    output logic [2:0] idx
);
    // High level sources beat low; lowest index wins inside a level
    always_comb begin
        found = 1'b0;
        win_hi = 1'b0;
        idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && !hi[i] && !win_hi) begin
                found = 1'b1;
                idx = 3'(i);
            end
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && hi[i]) begin
                found = 1'b1;
                win_hi = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule : ext_irq_arbiter
`default_nettype wire

// [ext_irq_extension.sv]
// Purpose: Two added external interrupts, vector table and polling logic
// Assumes: Classic Wishbone slave, one clock, core handshake via registers
// Notes: Legacy sources arrive as levels with their own enables/priorities
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - The added inputs work like the legacy external interrupts but use the control register.
// - The control register sits at C0 and each bit can be written on its own.
// - Bits 7 and 3 pick high or low priority for inputs b and a.
// - Bits 6 and 2 enable inputs b and a.
// - Bits 4 and 0 pick falling edge or low level for inputs b and a.
// - In edge mode hardware sets bits 5 and 1 on a request and clears them on service.
// - Legacy sources vector to 03, 0B, 13, 1B, 23 and 2B.
// - Input a vectors to 33.
// - Input b vectors to 3B.
// - Within a level, sources poll ext0, tmr0, ext1, tmr1, serial, tmr2, a, then b.
// - In emulation mode the added inputs and their state stay frozen.
module ext_irq_extension (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [5:0] legacy_req,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] ctl;
        logic [5:0] leg_en;
        logic [5:0] leg_hi;
        logic [2:0] ev_status;
        logic [2:0] ev_mask;
        logic emu;
        logic in_lo;
        logic in_hi;
        logic [2:0] cur_idx;
        logic req;
        logic [7:0] vector;
        logic irq;
        logic [31:0] dat;
        logic ack;
    } state_t;
    state_t st, next_st;
    logic a_req, b_req, a_pend, b_pend, a_edge, b_edge;
    logic found, win_hi;
    logic [2:0] win_idx;
    logic [7:0] src_req, src_hi;
    logic wr, rd, ctl_wr, serviced, reti;
    logic [7:0] vec_tab [8];
    // ****************************************
    // Vector table in polling order
    // ****************************************
    assign vec_tab[0] = ext_irq_pkg::VEC_EXT0;
    assign vec_tab[1] = ext_irq_pkg::VEC_TMR0;
    assign vec_tab[2] = ext_irq_pkg::VEC_EXT1;
    assign vec_tab[3] = ext_irq_pkg::VEC_TMR1;
    assign vec_tab[4] = ext_irq_pkg::VEC_SER;
    assign vec_tab[5] = ext_irq_pkg::VEC_TMR2;
    assign vec_tab[6] = ext_irq_pkg::VEC_XA;
    assign vec_tab[7] = ext_irq_pkg::VEC_XB;
    // Bus strobes; one access per ack, ack drops the cycle after
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
    assign ctl_wr = wr && wb_sel_i[0] && wb_adr_i == ext_irq_pkg::XCTL_OFFSET;
    // Service and return pulses are write-one commands from the core
    assign serviced = wr && wb_sel_i[0] && wb_adr_i == ext_irq_pkg::CORE_OFFSET
        && wb_dat_i[ext_irq_pkg::CORE_ACK_BIT] && st.req;
    assign reti = wr && wb_sel_i[0] && wb_adr_i == ext_irq_pkg::CORE_OFFSET
        && wb_dat_i[ext_irq_pkg::CORE_RETI_BIT];
    // ****************************************
    // Added input channels
    // ****************************************
    ext_irq_input u_in_a (
        .clk(clk),
        .rstn(rstn),
        .pin(ext_irq_pin_a),
        .freeze(st.emu),
        .edge_mode(st.ctl[ext_irq_pkg::A_TRIG_BIT]),
        .sw_wr(ctl_wr && !st.emu),
        .sw_pend(wb_dat_i[ext_irq_pkg::A_PEND_BIT]),
        .serviced(serviced && st.cur_idx == 3'h6),
        .request(a_req),
        .pend(a_pend),
        .edge_seen(a_edge)
    );
    ext_irq_input u_in_b (
        .clk(clk),
        .rstn(rstn),
        .pin(ext_irq_pin_b),
        .freeze(st.emu),
        .edge_mode(st.ctl[ext_irq_pkg::B_TRIG_BIT]),
        .sw_wr(ctl_wr && !st.emu),
        .sw_pend(wb_dat_i[ext_irq_pkg::B_PEND_BIT]),
        .serviced(serviced && st.cur_idx == 3'h7),
        .request(b_req),
        .pend(b_pend),
        .edge_seen(b_edge)
    );
    // Enables gate requests; in-service state blocks equal or lower levels
    always_comb begin
        src_req = {b_req && st.ctl[ext_irq_pkg::B_EN_BIT] && !st.emu,
                   a_req && st.ctl[ext_irq_pkg::A_EN_BIT] && !st.emu,
                   legacy_req & st.leg_en};
        src_hi = {st.ctl[ext_irq_pkg::B_PRIO_BIT], st.ctl[ext_irq_pkg::A_PRIO_BIT],
                  st.leg_hi};
        if (st.in_hi)
            src_req = 8'h00;
        else if (st.in_lo)
            src_req = src_req & src_hi;
    end
    ext_irq_arbiter #(.N(ext_irq_pkg::NUM_SRC)) u_arb (
        .req(src_req),
        .hi(src_hi),
        .found(found),
        .win_hi(win_hi),
        .idx(win_idx)
    );
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        // Offer the current winner while no service is being taken
        if (!st.req && found) begin
            next_st.req = 1'b1;
            next_st.cur_idx = win_idx;
            next_st.vector = vec_tab[win_idx];
        end
        if (serviced) begin
            next_st.req = 1'b0;
            if (src_hi[st.cur_idx])
                next_st.in_hi = 1'b1;
            else
                next_st.in_lo = 1'b1;
        end else if (st.req && !found) begin
            next_st.req = 1'b0; // Level request went away before service
        end else if (st.req && found && win_idx != st.cur_idx) begin
            next_st.cur_idx = win_idx;
            next_st.vector = vec_tab[win_idx];
        end
        if (reti) begin
            if (st.in_hi)
                next_st.in_hi = 1'b0;
            else
                next_st.in_lo = 1'b0;
        end
        if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                ext_irq_pkg::XCTL_OFFSET:
                    if (!st.emu)
                        next_st.ctl = wb_dat_i[7:0];
                ext_irq_pkg::IRQ_STATUS_OFFSET:
                    next_st.ev_status = st.ev_status & ~wb_dat_i[2:0];
                ext_irq_pkg::IRQ_MASK_OFFSET:
                    next_st.ev_mask = wb_dat_i[2:0];
                ext_irq_pkg::CORE_OFFSET:
                    next_st.emu = wb_dat_i[ext_irq_pkg::CORE_EMU_BIT];
                ext_irq_pkg::LEGACY_OFFSET: begin
                    next_st.leg_en = wb_dat_i[5:0];
                    next_st.leg_hi = wb_dat_i[13:8];
                end
                default: ;
            endcase
        end
        // Pending flags mirror the channel state
        next_st.ctl[ext_irq_pkg::A_PEND_BIT] = a_pend;
        next_st.ctl[ext_irq_pkg::B_PEND_BIT] = b_pend;
        // Sticky events, set wins over the write-one clear
        if (serviced)
            next_st.ev_status[ext_irq_pkg::EV_TAKEN_BIT] = 1'b1;
        if (a_edge)
            next_st.ev_status[ext_irq_pkg::EV_A_BIT] = 1'b1;
        if (b_edge)
            next_st.ev_status[ext_irq_pkg::EV_B_BIT] = 1'b1;
        next_st.irq = |(next_st.ev_status & next_st.ev_mask);
        // Read data; unmapped offsets read zero
        next_st.dat = 32'h0000_0000;
        if (rd) begin
            unique case (wb_adr_i)
                ext_irq_pkg::XCTL_OFFSET: next_st.dat = {24'h000000, st.ctl};
                ext_irq_pkg::IRQ_STATUS_OFFSET: next_st.dat = {29'h0, st.ev_status};
                ext_irq_pkg::IRQ_MASK_OFFSET: next_st.dat = {29'h0, st.ev_mask};
                ext_irq_pkg::CORE_OFFSET:
                    next_st.dat = {27'h0, st.in_hi, st.in_lo, st.emu, 2'b00};
                ext_irq_pkg::VECTOR_OFFSET:
                    next_st.dat = {20'h0, st.req, st.cur_idx, st.vector};
                ext_irq_pkg::LEGACY_OFFSET:
                    next_st.dat = {18'h0, st.leg_hi, 2'b00, st.leg_en};
                default: next_st.dat = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
            st.ctl <= ext_irq_pkg::XCTL_RESET;
        end else begin
            st <= next_st;
        end
    end
    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign irq_req = st.req;
    assign irq_vector = st.vector;
    assign irq = st.irq;
    // ****************************************
    // Checks
    // ****************************************
    property p_vec_a;
        @(posedge clk) disable iff (!rstn)
        irq_req && st.cur_idx == 3'h6 |-> irq_vector == 8'h33;
    endproperty
    a_vec_a: assert property (p_vec_a) else $error("Input a vector wrong");
    property p_vec_b;
        @(posedge clk) disable iff (!rstn)
        irq_req && st.cur_idx == 3'h7 |-> irq_vector == 8'h3b;
    endproperty
    a_vec_b: assert property (p_vec_b) else $error("Input b vector wrong");
    property p_vec_leg;
        @(posedge clk) disable iff (!rstn)
        irq_req && st.cur_idx == 3'h1 |-> irq_vector == 8'h0b;
    endproperty
    a_vec_leg: assert property (p_vec_leg) else $error("Timer 0 vector wrong");
    property p_freeze;
        @(posedge clk) disable iff (!rstn)
        st.emu && $past(st.emu) |-> $stable(st.ctl);
    endproperty
    a_freeze: assert property (p_freeze) else $error("Control moved in emulation");
    property p_hi_block;
        @(posedge clk) disable iff (!rstn)
        st.in_hi && !irq_req |=> !irq_req;
    endproperty
    a_hi_block: assert property (p_hi_block) else $error("High routine preempted");
    property p_clear_on_service;
        @(posedge clk) disable iff (!rstn)
        serviced && st.cur_idx == 3'h6 && st.ctl[0] && !a_edge |=> !a_pend [*1];
    endproperty
    a_clear_on_service: assert property (p_clear_on_service)
        else $error("Pending not cleared");
    sequence s_req_a;
        src_req == 8'h40 && !st.req;
    endsequence
    property p_poll;
        @(posedge clk) disable iff (!rstn)
        src_req[0] && !st.req |=> irq_req && st.cur_idx == 3'h0 || src_hi != 8'h00;
    endproperty
    a_poll: assert property (p_poll) else $error("Polling order broken");
    property p_en_gate;
        @(posedge clk) disable iff (!rstn)
        s_req_a |=> irq_req ##0 st.cur_idx == 3'h6;
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("Enabled input not offered");
    // Pending bits are left out: they mirror the channels one cycle late
    property p_ctl_write;
        @(posedge clk) disable iff (!rstn)
        ctl_wr && !st.emu |=> (st.ctl & 8'hdd) == ($past(wb_dat_i[7:0]) & 8'hdd);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("Control write lost");
    property p_hi_first;
        @(posedge clk) disable iff (!rstn)
        |(src_req & src_hi) |-> found && win_hi;
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("Low level beat high");
    property p_in_hi_gate;
        @(posedge clk) disable iff (!rstn)
        st.in_hi |-> src_req == 8'h00;
    endproperty
    a_in_hi_gate: assert property (p_in_hi_gate) else $error("Request under high");
    // A detected edge must win over any clear in the same cycle
    property p_edge_set_a;
        @(posedge clk) disable iff (!rstn)
        a_edge |=> a_pend;
    endproperty
    a_edge_set_a: assert property (p_edge_set_a) else $error("Edge a not latched");
    property p_edge_set_b;
        @(posedge clk) disable iff (!rstn)
        b_edge |=> b_pend;
    endproperty
    a_edge_set_b: assert property (p_edge_set_b) else $error("Edge b not latched");
    property p_dis_a;
        @(posedge clk) disable iff (!rstn)
        !st.ctl[ext_irq_pkg::A_EN_BIT] |-> !src_req[6];
    endproperty
    a_dis_a: assert property (p_dis_a) else $error("Disabled a requests");
    property p_dis_b;
        @(posedge clk) disable iff (!rstn)
        !st.ctl[ext_irq_pkg::B_EN_BIT] |-> !src_req[7];
    endproperty
    a_dis_b: assert property (p_dis_b) else $error("Disabled b requests");
    property p_emu_hold;
        @(posedge clk) disable iff (!rstn)
        st.emu |-> src_req[7:6] == 2'b00;
    endproperty
    a_emu_hold: assert property (p_emu_hold) else $error("Request while frozen");
    property p_vec_ext0;
        @(posedge clk) disable iff (!rstn)
        irq_req && st.cur_idx == 3'h0 |-> irq_vector == 8'h03;
    endproperty
    a_vec_ext0: assert property (p_vec_ext0) else $error("Ext0 vector wrong");
    // Service of a source takes its offer away on the next edge
    sequence s_serve;
        serviced && st.req;
    endsequence
    property p_serve_drop;
        @(posedge clk) disable iff (!rstn)
        s_serve |=> !irq_req;
    endproperty
    a_serve_drop: assert property (p_serve_drop) else $error("Offer kept after service");
    // The level output is the registered view of the masked status
    property p_irq_level;
        @(posedge clk) disable iff (!rstn)
        irq == |(st.ev_status & st.ev_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");
    property p_ack_pulse;
        @(posedge clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held too long");
endmodule : ext_irq_extension
`default_nettype wire

// [irq_source_model.sv]
// Purpose: Far side model: interrupt pins and legacy request levels
// Assumes: Pins idle high, driven just after a rising edge
// Notes: Pins are pulled up, so the idle level is a real one, not a guess
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    input wire logic clk,
    output logic pin_a,
    output logic pin_b,
    output logic [5:0] legacy_req
);
    // ****************************************
    // Source drive
    // ****************************************
    initial begin
        pin_a = 1'b1;
        pin_b = 1'b1;
        legacy_req = 6'h00;
    end
    // Levels for both pins and the legacy sources
    task automatic set_src(input logic a, input logic b, input logic [5:0] l);
        pin_a <= a;
        pin_b <= b;
        legacy_req <= l;
    endtask : set_src
    // Short low pulse on pin a: one falling edge
    task automatic pulse_a();
        pin_a <= 1'b0;
        repeat (2) @(posedge clk);
        pin_a <= 1'b1;
    endtask : pulse_a
endmodule : irq_source_model
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the external interrupt extension
// Assumes: Classic Wishbone, answers seen at the sampling edge
// Notes: Pin events need 3 to 4 cycles to reach the outputs
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk;
    logic rstn;
    logic [7:0] adr;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic we;
    logic cyc;
    logic stb;
    logic ack;
    logic pin_a;
    logic pin_b;
    logic [5:0] legacy_req;
    logic irq_req;
    logic [7:0] irq_vector;
    logic irq;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] vt [8] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b};
    ext_irq_extension uut (.clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat_w),
        .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .legacy_req(legacy_req), .irq_req(irq_req), .irq_vector(irq_vector), .irq(irq));
    irq_source_model src (.clk(clk), .pin_a(pin_a), .pin_b(pin_b), .legacy_req(legacy_req));
    // ****************************************
    // Clock, reset and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is under 2000 cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One classic cycle; ack and data are read with their pre-edge values
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        adr <= a;
        we <= w;
        dat_w <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(nm, e, q);
    endtask : rd
    task automatic offer(input logic [7:0] v, input string nm);
        repeat (6) @(posedge clk);
        chk({nm, " req"}, 32'h1, {31'h0, irq_req});
        chk({nm, " vec"}, {24'h0, v}, {24'h0, irq_vector});
    endtask : offer
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        {adr, dat_w, we, cyc, stb} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(ext_irq_pkg::XCTL_OFFSET, 32'h0, "ctl reset");
        wr(8'hfc, 32'hff);
        rd(8'hfc, 32'h0, "unmapped");
        // Each control bit on its own, pending flags included
        for (int i = 0; i < 8; i++) begin
            wr(ext_irq_pkg::XCTL_OFFSET, 32'h1 << i);
            rd(ext_irq_pkg::XCTL_OFFSET, 32'h1 << i, "ctl bit");
        end
        // Edge on a while disabled: flag sets, nothing offered
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h01);
        src.pulse_a();
        repeat (6) @(posedge clk);
        chk("disabled req", 32'h0, {31'h0, irq_req});
        rd(ext_irq_pkg::XCTL_OFFSET, 32'h03, "flag when off");
        // Edge on a enabled: vector, then service clears the flag
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h07);
        offer(8'h33, "edge a");
        rd(ext_irq_pkg::VECTOR_OFFSET, 32'h0e33, "vector reg");
        wr(ext_irq_pkg::CORE_OFFSET, 32'h1);
        rd(ext_irq_pkg::XCTL_OFFSET, 32'h05, "flag cleared");
        chk("served req", 32'h0, {31'h0, irq_req});
        wr(ext_irq_pkg::CORE_OFFSET, 32'h2);
        // Sticky events, mask and the level output
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ext_irq_pkg::IRQ_MASK_OFFSET, 32'h2);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(ext_irq_pkg::IRQ_STATUS_OFFSET, 32'h7);
        rd(ext_irq_pkg::IRQ_STATUS_OFFSET, 32'h0, "status clr");
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Low level on b: offered only while the pin is low
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h40);
        src.set_src(1'b1, 1'b0, 6'h00);
        offer(8'h3b, "level b");
        src.set_src(1'b1, 1'b1, 6'h00);
        repeat (6) @(posedge clk);
        chk("level b gone", 32'h0, {31'h0, irq_req});
        // All eight at one level; drop the winner each step
        wr(ext_irq_pkg::LEGACY_OFFSET, 32'h3f);
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h44);
        src.set_src(1'b0, 1'b0, 6'h3f);
        for (int i = 0; i < 8; i++) begin
            offer(vt[i], "poll");
            src.set_src(i >= 6, i >= 7, 6'h3e << i);
        end
        // High b beats a low ext0; a high routine blocks everything
        wr(ext_irq_pkg::XCTL_OFFSET, 32'hc0);
        src.set_src(1'b1, 1'b0, 6'h01);
        offer(8'h3b, "high b");
        wr(ext_irq_pkg::CORE_OFFSET, 32'h1);
        repeat (3) @(posedge clk);
        chk("in high", 32'h0, {31'h0, irq_req});
        wr(ext_irq_pkg::CORE_OFFSET, 32'h2);
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h40);
        offer(8'h03, "low b");
        // Serve ext0 at low level, then raise b to high: it preempts
        wr(ext_irq_pkg::CORE_OFFSET, 32'h1);
        wr(ext_irq_pkg::XCTL_OFFSET, 32'hc0);
        offer(8'h3b, "preempt");
        wr(ext_irq_pkg::CORE_OFFSET, 32'h2);
        // Frozen: control write and pin edge both have no effect
        src.set_src(1'b1, 1'b1, 6'h00);
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h05);
        wr(ext_irq_pkg::CORE_OFFSET, 32'h4);
        wr(ext_irq_pkg::XCTL_OFFSET, 32'h00);
        src.pulse_a();
        repeat (6) @(posedge clk);
        rd(ext_irq_pkg::XCTL_OFFSET, 32'h05, "frozen");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
